//--- logic/irta_entry_store.sv
`timescale 1ns/100ps

module irta_entry_store
	import irta_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic wr_en,
	input wire irta_idx_t wr_idx,
	input wire logic [15:0] wr_data,
	input wire irta_idx_t rd_idx,
	output logic [15:0] rd_data,
	input wire irta_idx_t meter_idx,
	output logic [15:0] meter_data,
	output logic [15:0] cbs,
	output logic [15:0] ebs
);

	logic [15:0] entry [IRTA_ENTRY_COUNT];

	// Out-of-range indices read as zero instead of aliasing an entry
	function automatic logic [15:0] fetch(input irta_idx_t idx);
		logic [15:0] val;
		val = 16'h0000;
		if (idx < 5'(IRTA_ENTRY_COUNT)) begin
			val = entry[idx];
		end
		return val;
	endfunction : fetch

	// One 16-bit flop word per entry, each with its own reset value
	generate
		for (genvar i = 0; i < IRTA_ENTRY_COUNT; i++) begin : g_entry
			localparam logic [15:0] RST_VAL = (i < IRTA_CIR_COUNT) ?
				IRTA_CIR_RESET : IRTA_BURST_RESET;
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					entry[i] <= RST_VAL;
				end else if (wr_en && (wr_idx == 5'(i))) begin
					entry[i] <= wr_data;
				end
			end
		end
	endgenerate

	// Read ports for software and for the metering datapath
	assign rd_data = fetch(rd_idx);
	assign meter_data = fetch(meter_idx);
	assign cbs = entry[IRTA_IDX_CBS];
	assign ebs = entry[IRTA_IDX_EBS];

endmodule : irta_entry_store

//--- logic/irta_pkg.sv
package irta_pkg;

	// Clock of the block
	localparam int unsigned IRTA_CLK_PERIOD_NS = 8;

	// Register numbers as seen on the register port
	localparam logic [15:0] IRTA_REG_COMMAND = 16'h184b;
	localparam logic [15:0] IRTA_REG_CMD_STATUS = 16'h184c;
	localparam logic [15:0] IRTA_REG_WRITE_DATA = 16'h184d;
	localparam logic [15:0] IRTA_REG_READ_DATA = 16'h184e;
	localparam logic [15:0] IRTA_REG_PORT0_FILTERED = 16'h1850;
	localparam logic [15:0] IRTA_REG_PORT1_FILTERED = 16'h1851;

	// Table layout: committed-rate entries first, then the two burst sizes
	localparam int IRTA_CIR_COUNT = 24;
	localparam int IRTA_ENTRY_COUNT = 26;
	localparam logic [4:0] IRTA_IDX_CBS = 5'h18;
	localparam logic [4:0] IRTA_IDX_EBS = 5'h19;
	localparam int IRTA_PORT_COUNT = 2;

	// Values after reset
	localparam logic [15:0] IRTA_BURST_RESET = 16'h0600;
	localparam logic [15:0] IRTA_CIR_RESET = 16'h0014;
	localparam logic [15:0] IRTA_WDATA_RESET = 16'h0000;
	localparam logic [15:0] IRTA_RDATA_RESET = 16'h0000;
	localparam logic [7:0] IRTA_CMD_RESET = 8'h00;
	localparam logic [31:0] IRTA_CNT_RESET = 32'h0000_0000;
	localparam logic [31:0] IRTA_CNT_MAX = 32'hffff_ffff;

	// Command field positions
	localparam int IRTA_CMD_DIR_BIT = 7;
	localparam int IRTA_CMD_TYPE_HI = 6;
	localparam int IRTA_CMD_TYPE_LO = 5;
	localparam int IRTA_CMD_IDX_HI = 4;
	localparam int IRTA_PEND_BIT = 0;

	// Command target codes
	localparam logic [1:0] IRTA_TYPE_RSVD = 2'h0;
	localparam logic [1:0] IRTA_TYPE_CIR = 2'h1;
	localparam logic [1:0] IRTA_TYPE_CBS = 2'h2;
	localparam logic [1:0] IRTA_TYPE_EBS = 2'h3;

	// Committed-rate time step per count, in ns
	localparam logic [21:0] IRTA_RATE_STEP_NS = 22'h000014;

	typedef logic [4:0] irta_idx_t;

	typedef enum logic [1:0] {
		IRTA_IDLE = 2'b00,
		IRTA_BUSY = 2'b01
	} irta_state_e;

endpackage : irta_pkg

//--- logic/irta_rate_table.sv
// Operation
// - Table holds 24 committed-rate entries plus one committed and one excess burst.
// - Every table entry is 16 bits, reached only through command and data registers.
// - Excess burst size is a byte limit resetting to 0600h; excess drops beyond it.
// - Excess buckets start at default; smaller programmed value caps only after draining.
// - Committed burst size is a byte limit resetting to 0600h; beyond it random drop.
// - Committed buckets start at default; smaller programmed value caps only after draining.
// - Committed-rate entry means (value plus 1) times 20 ns per byte; resets 0014h.
// - Status bit 0 reads 1 while a table access runs, self-clears; resets 0.
// - Write-data bits 15:0 hold the value to store; reset 0000h, upper bits zero.
// - Read-data bits 15:0 show the entry fetched by the last read command.
// - Per-port counter counts ingress-filtered packets, not rate-limit drops.
// - Reading a 32-bit filtered counter returns its value and clears it.
// - Filtered counters saturate at all ones instead of wrapping.
// - Port 0 and port 1 counters sit at register numbers 1850h and 1851h.
// - Writing the command register starts the access; load write data first.
// - Command bit 7 selects direction: 1 read, 0 write.
// - Command bits 6:5 pick target: 01 rate, 10 committed, 11 excess, 00 reserved.
// - Command bits 4:0 index one of 24 committed-rate entries.
`timescale 1ns/100ps

module irta_rate_table
	import irta_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rd_valid,
	input wire logic [1:0] filtered_pkt,
	input wire logic [1:0] rate_limit_drop,
	input wire irta_idx_t meter_idx,
	output logic [21:0] meter_byte_time_ns,
	output logic [15:0] committed_burst_limit,
	output logic [15:0] excess_burst_limit,
	output logic [15:0] bucket_start_level,
	output logic table_busy
);

	irta_state_e state;
	irta_state_e next_state;
	logic [7:0] command;
	logic [15:0] write_data;
	logic [15:0] read_data;
	logic [31:0] filt_count [IRTA_PORT_COUNT];
	logic [IRTA_PORT_COUNT-1:0] filt_inc;
	logic [IRTA_PORT_COUNT-1:0] filt_clr;

	// Map a command's target and index onto a store slot; top bit flags a valid slot
	function automatic logic [5:0] slot_of(input logic [1:0] kind, input logic [4:0] idx);
		logic [5:0] res;
		res = 6'h00;
		case (kind)
			IRTA_TYPE_CIR: begin
				if (idx < 5'(IRTA_CIR_COUNT)) begin
					res = {1'b1, idx};
				end
			end
			IRTA_TYPE_CBS: begin
				res = {1'b1, IRTA_IDX_CBS};
			end
			IRTA_TYPE_EBS: begin
				res = {1'b1, IRTA_IDX_EBS};
			end
			default: begin
				res = 6'h00; // Reserved target does nothing
			end
		endcase
		return res;
	endfunction : slot_of

	// Command field decode
	wire cmd_dir_read = command[IRTA_CMD_DIR_BIT];
	wire [1:0] cmd_type = command[IRTA_CMD_TYPE_HI:IRTA_CMD_TYPE_LO];
	wire [4:0] cmd_idx = command[IRTA_CMD_IDX_HI:0];
	wire [5:0] cmd_slot = slot_of(cmd_type, cmd_idx);
	wire slot_ok = cmd_slot[5];

	// Register port decode
	wire hit_cmd = (reg_addr == IRTA_REG_COMMAND);
	wire hit_wdata = (reg_addr == IRTA_REG_WRITE_DATA);
	wire hit_cnt0 = (reg_addr == IRTA_REG_PORT0_FILTERED);
	wire hit_cnt1 = (reg_addr == IRTA_REG_PORT1_FILTERED);
	wire is_idle = (state == IRTA_IDLE);
	// A command written while one runs is dropped, so the running access stays coherent
	wire cmd_start = reg_wr_en && hit_cmd && is_idle;
	wire busy_now = (state == IRTA_BUSY);
	wire tbl_wr = busy_now && !cmd_dir_read && slot_ok;
	wire tbl_rd = busy_now && cmd_dir_read;

	wire [15:0] store_rd_data;
	wire [15:0] store_meter_data;
	wire [15:0] store_cbs;
	wire [15:0] store_ebs;

	// Table storage, written only through the command path; the datapath reads it directly
	irta_entry_store u_store (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.wr_en(tbl_wr),
		.wr_idx(cmd_slot[4:0]),
		.wr_data(write_data),
		.rd_idx(cmd_slot[4:0]),
		.rd_data(store_rd_data),
		.meter_idx(meter_idx),
		.meter_data(store_meter_data),
		.cbs(store_cbs),
		.ebs(store_ebs)
	);

	// Filtered counters: rate-limit drops are counted elsewhere, so they are masked here
	assign filt_inc = filtered_pkt & ~rate_limit_drop;
	assign filt_clr = {reg_rd_en && hit_cnt1, reg_rd_en && hit_cnt0};

	generate
		for (genvar p = 0; p < IRTA_PORT_COUNT; p++) begin : g_port
			irta_sat_counter u_count (
				.sys_clk(sys_clk),
				.sys_rst(sys_rst),
				.inc(filt_inc[p]),
				.clr(filt_clr[p]),
				.count(filt_count[p])
			);
		end
	endgenerate

	// Read mux; unmapped numbers and reserved bits read as zero
	wire [31:0] rd_mux =
		hit_cmd ? {24'h0, command} :
		(reg_addr == IRTA_REG_CMD_STATUS) ? {31'h0, busy_now} :
		hit_wdata ? {16'h0, write_data} :
		(reg_addr == IRTA_REG_READ_DATA) ? {16'h0, read_data} :
		hit_cnt0 ? filt_count[0] :
		hit_cnt1 ? filt_count[1] :
		32'h0000_0000;

	// Access sequencer: one idle-to-busy step per command
	always_comb begin
		next_state = state;
		case (state)
			IRTA_IDLE: begin
				if (cmd_start) begin
					next_state = IRTA_BUSY;
				end
			end
			IRTA_BUSY: begin
				next_state = IRTA_IDLE;
			end
			default: begin
				next_state = IRTA_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= IRTA_IDLE;
			table_busy <= 1'b0;
		end else begin
			state <= next_state;
			table_busy <= (next_state == IRTA_BUSY);
		end
	end

	// Command and write-data registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			command <= IRTA_CMD_RESET;
			write_data <= IRTA_WDATA_RESET;
		end else begin
			if (cmd_start) begin
				command <= reg_wdata[7:0];
			end
			if (reg_wr_en && hit_wdata) begin
				write_data <= reg_wdata[15:0];
			end
		end
	end

	// Read-data capture; an invalid slot returns zero
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			read_data <= IRTA_RDATA_RESET;
		end else if (tbl_rd) begin
			read_data <= slot_ok ? store_rd_data : 16'h0000;
		end
	end

	// Register port answer, one cycle after the read strobe
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rdata <= rd_mux;
			end
		end
	end

	// Datapath views: byte time, burst caps and the fixed bucket start level.
	// Buckets load the reset default, never the programmed size, so a lower cap
	// only bites once a bucket has drained below it.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meter_byte_time_ns <= 22'h000000;
			committed_burst_limit <= IRTA_BURST_RESET;
			excess_burst_limit <= IRTA_BURST_RESET;
			bucket_start_level <= IRTA_BURST_RESET;
		end else begin
			meter_byte_time_ns <= 22'(({6'h00, store_meter_data} + 22'h1) *
				IRTA_RATE_STEP_NS);
			committed_burst_limit <= store_cbs;
			excess_burst_limit <= store_ebs;
			bucket_start_level <= IRTA_BURST_RESET;
		end
	end

	// Pending rises on the edge after the command and falls one edge later
	chk_pend_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cmd_start |=> (table_busy ##1 !table_busy))
		else $error("pending flag did not show a single busy cycle");

	// Status register reads the pending flag
	chk_status_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(reg_rd_en && reg_addr == IRTA_REG_CMD_STATUS) |=>
		(reg_rd_valid && reg_rdata == {31'h0, $past(table_busy)}))
		else $error("status read did not return pending flag");

	// A read command of the excess burst fetches it into read data
	chk_read_fetch: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cmd_start && reg_wdata[7:5] == {1'b1, IRTA_TYPE_EBS}) |=> ##1
		(read_data == $past(store_ebs)))
		else $error("read command did not fetch the excess burst entry");

	// A write command stores write data into the committed burst entry
	chk_write_store: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(tbl_wr && cmd_type == IRTA_TYPE_CBS) |=> (store_cbs == $past(write_data)))
		else $error("write command did not store committed burst");

	// Reserved target leaves both burst entries alone
	chk_rsvd_noop: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(busy_now && cmd_type == IRTA_TYPE_RSVD) |=>
		($stable(store_cbs) && $stable(store_ebs)))
		else $error("reserved target changed the table");

	// Byte time follows the rate entry with one cycle of latency
	chk_byte_time: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$stable(store_meter_data) |=> (meter_byte_time_ns ==
		22'(({6'h00, $past(store_meter_data)} + 22'h1) * IRTA_RATE_STEP_NS)))
		else $error("byte time does not match rate entry");

	// Rate-limit drops never reach the port 0 filtered counter
	chk_drop_excluded: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(rate_limit_drop[0] && !filt_clr[0]) |=> $stable(filt_count[0]))
		else $error("rate-limit drop was counted as filtered");

	// Commands during an access are ignored
	chk_busy_refuse: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(busy_now && reg_wr_en && hit_cmd) |=> $stable(command))
		else $error("command register changed during an access");

	// Write-data register shows zeros in its reserved upper half
	chk_wdata_upper: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(reg_rd_en && hit_wdata) |=> (reg_rdata[31:16] == 16'h0000))
		else $error("write-data read showed reserved bits");

	// A counter read returns the count held at the read edge
	chk_count_return: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(reg_rd_en && hit_cnt1) |=> (reg_rdata == $past(filt_count[1])))
		else $error("counter read returned a wrong value");

	// Every read strobe gets its answer pulse one cycle later
	chk_answer_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_rd_en |=> reg_rd_valid)
		else $error("read strobe got no answer pulse");

	// A stored excess burst reaches the datapath cap one cycle after the entry
	chk_excess_cap_copy: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(tbl_wr && cmd_type == IRTA_TYPE_EBS) |=> ##1
		(excess_burst_limit == $past(write_data, 2)))
		else $error("excess burst cap did not follow the table entry");

	// Buckets always load the default level, whatever size is programmed
	chk_start_level: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bucket_start_level == IRTA_BURST_RESET)
		else $error("bucket start level differs from the default burst");

	// An accepted command is latched exactly as written
	chk_cmd_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cmd_start |=> (command == $past(reg_wdata[7:0])))
		else $error("accepted command was not latched");

	// A read of an invalid slot leaves zero in read data
	chk_invalid_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(tbl_rd && !slot_ok) |=> (read_data == 16'h0000))
		else $error("invalid slot read did not return zero");

	// Pending lasts a single cycle and then the sequencer is idle again
	chk_pend_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
		busy_now |=> is_idle)
		else $error("pending flag did not clear after the access");

endmodule : irta_rate_table

//--- logic/irta_sat_counter.sv
`timescale 1ns/100ps

module irta_sat_counter
	import irta_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic inc,
	input wire logic clr,
	output logic [31:0] count
);

	logic at_max;
	logic [31:0] next_count;

	// A clear by read and a new event in one cycle leave a count of one
	assign at_max = (count == IRTA_CNT_MAX);
	assign next_count = clr ? {31'h0, inc} :
		((inc && !at_max) ? count + 32'h1 : count);

	// Counter state
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= IRTA_CNT_RESET;
		end else begin
			count <= next_count;
		end
	end

	// Saturation holds all-ones while no clear comes
	chk_sat_hold_max: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(at_max && !clr) |=> (count == IRTA_CNT_MAX))
		else $error("filtered counter left its maximum without a clear");

	// A read clears the count, keeping only a coincident event
	chk_clear_on_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clr |=> (count == {31'h0, $past(inc)}))
		else $error("filtered counter not cleared by read");

	// Each event below maximum adds exactly one
	chk_count_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(inc && !clr && !at_max) |=> (count == $past(count) + 32'h1))
		else $error("filtered counter did not advance by one");

endmodule : irta_sat_counter

//--- testbench/irta_rate_table_tb_top.sv
`timescale 1ns/100ps

module irta_rate_table_tb_top
	import irta_pkg::*;
;
	logic sys_clk;
	logic sys_rst;
	logic [15:0] reg_addr;
	logic reg_wr_en;
	logic reg_rd_en;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic reg_rd_valid;
	logic [1:0] filtered_pkt;
	logic [1:0] rate_limit_drop;
	irta_idx_t meter_idx;
	logic [21:0] meter_byte_time_ns;
	logic [15:0] committed_burst_limit;
	logic [15:0] excess_burst_limit;
	logic [15:0] bucket_start_level;
	logic table_busy;
	logic [31:0] rd;
	int n_fail;
	int tests_run;

	irta_rate_table irta_rate_table_i (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid),
		.filtered_pkt(filtered_pkt),
		.rate_limit_drop(rate_limit_drop),
		.meter_idx(meter_idx),
		.meter_byte_time_ns(meter_byte_time_ns),
		.committed_burst_limit(committed_burst_limit),
		.excess_burst_limit(excess_burst_limit),
		.bucket_start_level(bucket_start_level),
		.table_busy(table_busy)
	);

	// Free-running 125 MHz clock
	always #4 sys_clk = ~sys_clk;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task conclude;
		$display("Counts: %0d compares, %0d mismatches", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	// One-cycle write strobe; an idle edge follows so back-to-back calls never share a step
	task reg_write(input logic [15:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
		@(posedge sys_clk);
	endtask : reg_write

	// Read with a bounded wait for the answer pulse
	task reg_read(input logic [15:0] a, output logic [31:0] d);
		int i;
		i = 0;
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge sys_clk);
		reg_rd_en <= 1'b0;
		@(negedge sys_clk);
		while (reg_rd_valid !== 1'b1 && i < 4) begin
			@(negedge sys_clk);
			i++;
		end
		check({31'h00000000, reg_rd_valid}, 32'h0000_0001);
		d = reg_rdata;
		@(posedge sys_clk);
	endtask : reg_read

	// Issue a table command, then read the status register while the access is pending
	task table_op(input logic [7:0] cmd);
		reg_addr <= IRTA_REG_COMMAND;
		reg_wdata <= {24'h000000, cmd};
		reg_wr_en <= 1'b1;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
		reg_addr <= IRTA_REG_CMD_STATUS;
		reg_rd_en <= 1'b1;
		@(negedge sys_clk);
		check({31'h00000000, table_busy}, 32'h0000_0001);
		@(posedge sys_clk);
		reg_rd_en <= 1'b0;
		@(negedge sys_clk);
		check({31'h00000000, table_busy}, 32'h0000_0000);
		check(reg_rdata, 32'h0000_0001);
		@(posedge sys_clk);
	endtask : table_op

	task tbl_read(input logic [7:0] cmd, input logic [15:0] exp);
		logic [31:0] d;
		table_op(cmd);
		reg_read(IRTA_REG_READ_DATA, d);
		check(d, {16'h0000, exp});
	endtask : tbl_read

	// Write data goes in first, then the command
	task tbl_write(input logic [7:0] cmd, input logic [15:0] val);
		reg_write(IRTA_REG_WRITE_DATA, {16'h0000, val});
		table_op(cmd);
	endtask : tbl_write

	// Watchdog: the whole sequence needs well under 3000 cycles
	initial begin
		#100000;
		n_fail++;
		conclude();
	end

	initial begin
		sys_clk = 1'b0;
		sys_rst = 1'b1;
		reg_addr = 16'h0000;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_wdata = 32'h0000_0000;
		filtered_pkt = 2'h0;
		rate_limit_drop = 2'h0;
		meter_idx = 5'h00;
		n_fail = 0;
		tests_run = 0;
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		// Values after reset
		reg_read(IRTA_REG_CMD_STATUS, rd);
		check(rd, 32'h0000_0000);
		reg_read(IRTA_REG_WRITE_DATA, rd);
		check(rd, 32'h0000_0000);
		reg_read(IRTA_REG_READ_DATA, rd);
		check(rd, 32'h0000_0000);
		check({16'h0000, committed_burst_limit}, 32'h0000_0600);
		check({16'h0000, excess_burst_limit}, 32'h0000_0600);
		check({16'h0000, bucket_start_level}, 32'h0000_0600);
		check({10'h000, meter_byte_time_ns}, 32'h0000_01a4);
		for (int i = 0; i < 24; i++) tbl_read(8'ha0 | 8'(i), 16'h0014);
		tbl_read(8'hc0, 16'h0600);
		tbl_read(8'he0, 16'h0600);
		// Upper write-data bits are reserved and read back as zero
		reg_write(IRTA_REG_WRITE_DATA, 32'hdead_1234);
		reg_read(IRTA_REG_WRITE_DATA, rd);
		check(rd, 32'h0000_1234);
		// Every slot holds its own value, so an index slip shows up
		for (int i = 0; i < 24; i++) tbl_write(8'h20 | 8'(i), 16'h0100 + 16'(i));
		for (int i = 0; i < 24; i++) tbl_read(8'ha0 | 8'(i), 16'h0100 + 16'(i));
		tbl_write(8'h40, 16'h0200);
		tbl_write(8'h60, 16'h0300);
		tbl_read(8'hc0, 16'h0200);
		tbl_read(8'he0, 16'h0300);
		@(negedge sys_clk);
		check({16'h0000, committed_burst_limit}, 32'h0000_0200);
		check({16'h0000, excess_burst_limit}, 32'h0000_0300);
		check({16'h0000, bucket_start_level}, 32'h0000_0600);
		@(posedge sys_clk);
		// Reserved target changes nothing; reserved target and out-of-range index read zero
		tbl_write(8'h05, 16'hbeef);
		tbl_read(8'ha5, 16'h0105);
		tbl_read(8'h85, 16'h0000);
		tbl_read(8'hb8, 16'h0000);
		// Second command strobed while the first is pending is dropped
		reg_write(IRTA_REG_WRITE_DATA, 32'h0000_0777);
		reg_addr <= IRTA_REG_COMMAND;
		reg_wdata <= 32'h0000_0040;
		reg_wr_en <= 1'b1;
		@(posedge sys_clk);
		reg_wdata <= 32'h0000_0060;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
		repeat (2) @(posedge sys_clk);
		tbl_read(8'hc0, 16'h0777);
		tbl_read(8'he0, 16'h0300);
		// Excess burst back to its default, so it still covers the largest frame
		tbl_write(8'h60, 16'h0600);
		tbl_read(8'he0, 16'h0600);
		// Lookup of a programmed rate: (0105h + 1) * 20 ns
		meter_idx <= 5'h05;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		check({10'h000, meter_byte_time_ns}, 32'h0000_1478);
		@(posedge sys_clk);
		// Events: rate-limit drops are not filtered packets
		filtered_pkt <= 2'h3;
		repeat (5) @(posedge sys_clk);
		filtered_pkt <= 2'h1;
		rate_limit_drop <= 2'h1;
		@(posedge sys_clk);
		filtered_pkt <= 2'h2;
		rate_limit_drop <= 2'h0;
		@(posedge sys_clk);
		filtered_pkt <= 2'h0;
		@(posedge sys_clk);
		reg_read(IRTA_REG_PORT0_FILTERED, rd);
		check(rd, 32'h0000_0005);
		reg_read(IRTA_REG_PORT0_FILTERED, rd);
		check(rd, 32'h0000_0000);
		reg_read(IRTA_REG_PORT1_FILTERED, rd);
		check(rd, 32'h0000_0006);
		reg_read(IRTA_REG_PORT1_FILTERED, rd);
		check(rd, 32'h0000_0000);
		// An event on the read edge survives the clear and is counted afresh
		filtered_pkt <= 2'h1;
		reg_read(IRTA_REG_PORT0_FILTERED, rd);
		filtered_pkt <= 2'h0;
		check(rd, 32'h0000_0000);
		reg_read(IRTA_REG_PORT0_FILTERED, rd);
		check(rd, 32'h0000_0002);
		// Unmapped number answers zero
		reg_read(16'h1852, rd);
		check(rd, 32'h0000_0000);
		conclude();
	end

endmodule : irta_rate_table_tb_top
